// File: core/mtc_consts.svh
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH
// Overview of operation
// R1: Round-robin five channels, about 190 ms round.
// R2: Busy bit high only while converting.
// R3: Rate bits add idle gap, round unchanged.
// R4: Each channel can be disabled and skipped.
// R5: Results read zero until first conversion.
// R6: Remote one processor model, others transistor.
// R7: Offsets zero, converting, fault queue on.
// R8: Continuous, all channels, 1 s, enhanced filters.
// R9: Default limits and masks per output.
// R10: Slave only, clock input, never stretched.
// R11: Address 18h, 4Dh or 4Eh per pin.
// R12: Filtered result feeds limit compare.
// R13: Two-bit filter code for remotes one, two.
// R14: Queue: three highs assert unmasked output.
// R15: Queue: three lows below hysteresis release.
// R16: Config bits 0, 1 enable queues.
// R17: Left-justified 16-bit words, unused bits zero.
// R18: Results clamp at full scale.
// R19: Eleven-bit signed or unsigned, 0.125 degree.
// R20: Fixed read-only maker and revision codes.
// R21: Filter on gives thirteen bits, 0.03125 degree.
// R22: Local result eleven-bit signed only.
// R23: Line low past timeout resets serial port.
// R24: Next round after channels and gap.
// R25: Reserved filter code stored, acts unfiltered.

// ----------------------------------------
// Timing
// ----------------------------------------
`define MTC_CLK_KHZ     50000
`define MTC_ROUND_MS    190
`define MTC_IVL_MS      1000
`define MTC_TOUT_MS     25
`define MTC_NUM_CH      5

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MTC_REG_STATUS  8'h02
`define MTC_REG_CONFIG  8'h03
`define MTC_REG_CHEN    8'h05
`define MTC_REG_FILTER  8'h0f
`define MTC_REG_TS_MSB  8'h10
`define MTC_REG_TU_MSB  8'h18
`define MTC_REG_TS_LSB  8'h20
`define MTC_REG_TU_LSB  8'h28
`define MTC_REG_OFFSET  8'h30
`define MTC_REG_MODEL   8'h38
`define MTC_REG_LIM_A   8'h40
`define MTC_REG_LIM_B   8'h48
`define MTC_REG_HYST    8'h4f
`define MTC_REG_MASK_A  8'h50
`define MTC_REG_MASK_B  8'h51
`define MTC_REG_MASK_C  8'h52
`define MTC_REG_STAT_A  8'h53
`define MTC_REG_STAT_B  8'h54
`define MTC_REG_STAT_C  8'h55
`define MTC_REG_MFR     8'hfe
`define MTC_REG_REV     8'hff

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define MTC_ST_BUSY     7
`define MTC_ST_NRDY     6
`define MTC_CFG_STBY    6
`define MTC_FLT_STD     2'b01
`define MTC_FLT_ENH     2'b11
`define MTC_FQ_DEPTH    2'd3
`define MTC_ADDR_LO     7'h18
`define MTC_ADDR_MID    7'h4d
`define MTC_ADDR_HI     7'h4e

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define MTC_RST_CFG     8'h07
`define MTC_RST_CHEN    5'h1f
`define MTC_RST_FILT    4'hf
`define MTC_RST_MODEL   4'h1
`define MTC_LIM_HOT     8'h6e
`define MTC_LIM_STD     8'h55
`define MTC_RST_HYST    8'h05
`define MTC_RST_MASK_A  5'h19
`define MTC_RST_MASK_B  5'h00
`define MTC_RST_MASK_C  5'h07
`define MTC_MFR_ID      8'h5a
`define MTC_REV_ID      8'h13
`define MTC_CLIP        16'h0080
`define MTC_S_MIN       16'hf000
`define MTC_S_MAX       16'h0fff
`define MTC_U_MIN       16'h0000
`define MTC_U_MAX       16'h1fff
`endif

// File: core/mtc_pkg.sv
package mtc_pkg;
  typedef logic [1:0]  mtc_asel_t;  // Pin code: 00 low, 01 mid, 1x high
  typedef logic [13:0] mtc_adc_t;   // Signed sample, 1/32 degree per count
  typedef enum logic {SQ_WAIT, SQ_CONV} mtc_sq_t;
  typedef enum logic [2:0] {SM_IDLE, SM_RX, SM_ACK, SM_TX, SM_TXACK} mtc_sm_t;

  typedef struct packed {
    logic             scl_m, scl_s, scl_p;
    logic             sda_m, sda_s, sda_p;
    logic [1:0]       asel_m, asel_s;
    logic [7:0]       cfg;
    logic [4:0]       chen;
    logic [3:0]       filt;
    logic [3:0]       model;
    logic [3:0][7:0]  off;
    logic [4:0][7:0]  lim_a;
    logic [1:0][7:0]  lim_b;
    logic [7:0]       hyst;
    logic [4:0]       mask_a, mask_b, mask_c;
    logic [4:0]       ot_a, ot_b;
    logic [1:0][1:0]  fq_hi, fq_lo;
    logic [1:0][15:0] fy;
    logic [1:0]       fv;
    logic             nrdy;
    mtc_sq_t          sq;
    logic [2:0]       ch;
    logic [31:0]      slot, ivl, tmo;
    logic             adc_go;
    mtc_sm_t          sm;
    logic [3:0]       bcnt;
    logic [1:0]       bidx;
    logic             rw;
    logic [7:0]       sh, ptr;
    logic             dat_out, dat_oe;
    logic             ota_oe, otb_oe, otc_oe;
  } mtc_ctl_t;

  typedef struct packed {
    logic [7:0][31:0] mem;
    logic [31:0]      rd;
  } mtc_mem_t;
endpackage : mtc_pkg

// File: core/mtc_res_if.sv
`timescale 1ns/1ps
// Result store port: one write word per conversion, one read word
interface mtc_res_if;
  logic        we;
  logic [2:0]  waddr;
  logic [31:0] wdata;
  logic [2:0]  raddr;
  logic [31:0] rdata;
  modport wr  (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : mtc_res_if

// File: core/mtc_res_mem.sv
`timescale 1ns/1ps
// Result words per channel: {unsigned word, signed word}
module mtc_res_mem (
  input wire logic clk,
  input wire logic nrst,
  mtc_res_if.mem   port
);
  import mtc_pkg::*;

  mtc_mem_t q;  // Stored words and read register
  mtc_mem_t n;  // Next value

  // ----------------------------------------
  // Write and registered read
  // ----------------------------------------
  always_comb begin
    n = q;
    if (port.we) begin
      n.mem[port.waddr] = port.wdata;
    end
    n.rd = q.mem[port.raddr];
  end

  // R5: zero until converted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign port.rdata = q.rd;
endmodule : mtc_res_mem

// File: core/mtc_ctrl.sv
`timescale 1ns/1ps
`include "mtc_consts.svh"
// Conversion sequencer, filters, limit logic and serial slave port
module mtc_ctrl #(
  parameter int         CONV_CYC = `MTC_ROUND_MS * `MTC_CLK_KHZ / `MTC_NUM_CH,
  parameter int         IVL_CYC  = `MTC_IVL_MS * `MTC_CLK_KHZ,
  parameter int         TOUT_CYC = `MTC_TOUT_MS * `MTC_CLK_KHZ,
  // Identity codes; values are arbitrary
  parameter logic [7:0] MFR_ID   = `MTC_MFR_ID,
  parameter logic [7:0] REV_ID   = `MTC_REV_ID
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              smb_clk,
  input  wire logic              smb_dat,
  output logic                   smb_dat_out,
  output logic                   smb_dat_oe,
  input  wire mtc_pkg::mtc_asel_t address_select_pin,
  input  wire mtc_pkg::mtc_adc_t adc_data,
  output logic                   adc_start,
  output logic [2:0]             adc_chan,
  output logic [3:0]             diode_model,
  output logic                   overtemp_out_a_oe,
  output logic                   overtemp_out_b_oe,
  output logic                   overtemp_out_c_oe
);
  import mtc_pkg::*;

  // ----------------------------------------
  // State and result store
  // ----------------------------------------
  mtc_ctl_t q;    // All state
  mtc_ctl_t n;    // Next state
  mtc_res_if res ();

  mtc_res_mem u_mem (
    .clk  (clk),
    .nrst (nrst),
    .port (res.mem)
  );

  // R6 R7 R8 R9: power-up defaults
  localparam mtc_ctl_t CTL_RST = '{
    default: '0,
    scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
    cfg: `MTC_RST_CFG, chen: `MTC_RST_CHEN,
    filt: `MTC_RST_FILT, model: `MTC_RST_MODEL,
    lim_a: {`MTC_LIM_STD, `MTC_LIM_STD, `MTC_LIM_HOT,
            `MTC_LIM_HOT, `MTC_LIM_STD},
    lim_b: {`MTC_LIM_STD, `MTC_LIM_STD},
    hyst: `MTC_RST_HYST, mask_a: `MTC_RST_MASK_A,
    mask_b: `MTC_RST_MASK_B, mask_c: `MTC_RST_MASK_C,
    nrdy: 1'b1, sq: SQ_WAIT, ivl: '1, sm: SM_IDLE
  };

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Lowest enabled channel at or above a start index, 5 if none
  function automatic logic [2:0] next_en(input logic [4:0] en,
                                         input logic [2:0] from);
    logic [2:0] r;
    r = 3'd5;
    for (int i = 4; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : next_en

  // Signed clamp
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    if ($signed(v) < $signed(lo)) begin
      return lo;
    end
    if ($signed(v) > $signed(hi)) begin
      return hi;
    end
    return v;
  endfunction : clamp

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic        rise, fall, start, stop;
    logic        hires, above, below, fi, qi;
    logic [1:0]  fcode, hi, lo;
    logic [2:0]  nxt;
    logic [6:0]  addr;
    logic [7:0]  rdb;
    logic [15:0] x, d, v, sv, uv, th;
    logic [31:0] period;
    n = q;
    hires = 1'b0;
    above = 1'b0;
    below = 1'b0;
    fi = q.ch[1];
    qi = q.ch[2];
    fcode = 2'b00;
    hi = 2'b00;
    lo = 2'b00;
    nxt = 3'd5;
    d = 16'h0000;
    v = 16'h0000;
    sv = 16'h0000;
    uv = 16'h0000;
    th = 16'h0000;
    res.we = 1'b0;
    res.waddr = q.ch;
    res.wdata = 32'h0;
    res.raddr = q.ptr[2:0];

    // Pin synchronisers; edges and start/stop compare the second and third stages
    n.scl_m = smb_clk;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = smb_dat;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    n.asel_m = address_select_pin;
    n.asel_s = q.asel_m;
    rise = q.scl_s & ~q.scl_p;
    fall = ~q.scl_s & q.scl_p;
    start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

    // R11: address from pin level
    addr = q.asel_s[1] ? `MTC_ADDR_HI :
           (q.asel_s[0] ? `MTC_ADDR_MID : `MTC_ADDR_LO);

    // R3: interval per rate code; code 0 runs back to back
    period = (q.cfg[3:2] == 2'd0) ? 32'h0 :
             (32'(IVL_CYC) << 2'(q.cfg[3:2] - 2'd1));

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    n.adc_go = 1'b0;
    if (q.ivl != '1) begin
      n.ivl = q.ivl + 32'h1;
    end
    x = {{2{adc_data[13]}}, adc_data};
    unique case (q.sq)
      SQ_WAIT: begin
        nxt = next_en(q.chen, 3'd0);
        // R24: start after the interval, standby holds off
        if (!q.cfg[`MTC_CFG_STBY] && (q.ivl >= period) && (nxt != 3'd5)) begin
          n.sq = SQ_CONV;
          n.ch = nxt;
          n.slot = 32'h0;
          n.ivl = 32'h0;
          n.adc_go = 1'b1;
        end
      end
      SQ_CONV: begin
        if (q.slot != 32'(CONV_CYC - 1)) begin
          n.slot = q.slot + 32'h1;
        end else begin
          // Remote offset in 0.125 degree steps
          if (q.ch != 3'd0) begin
            x = x + {{6{q.off[2'(q.ch - 3'd1)][7]}}, q.off[2'(q.ch - 3'd1)], 2'b00};
          end
          v = x;
          // R12 R13: filters on remotes one and two
          if ((q.ch == 3'd1) || (q.ch == 3'd2)) begin
            fcode = fi ? q.filt[3:2] : q.filt[1:0];
            // R25: reserved code falls through unfiltered
            if ((fcode == `MTC_FLT_STD) || (fcode == `MTC_FLT_ENH)) begin
              hires = 1'b1;
              v = q.fv[fi] ? q.fy[fi] : x;
              d = q.fv[fi] ? (x - q.fy[fi]) : 16'h0000;
              // Transient clipping limits one step to 4 degrees
              if (fcode == `MTC_FLT_ENH) begin
                d = clamp(d, 16'(-`MTC_CLIP), `MTC_CLIP);
              end
              v = v + {{2{d[15]}}, d[15:2]};
              n.fy[fi] = v;
              n.fv[fi] = 1'b1;
            end
          end
          // R18: clamp at full scale
          sv = clamp(v, `MTC_S_MIN, `MTC_S_MAX);
          uv = clamp(v, `MTC_U_MIN, `MTC_U_MAX);
          // R19 R22: coarse results drop the two fine bits
          if (!hires) begin
            sv[1:0] = 2'b00;
            uv[1:0] = 2'b00;
          end
          // R17 R21: left-justified words
          res.we = 1'b1;
          res.wdata[15:0] = {sv[12:0], 3'b000};
          if (q.ch != 3'd0) begin
            res.wdata[31:16] = {uv[12:0], 3'b000};
          end
          // Limit compare with shared hysteresis
          th = {3'h0, q.lim_a[q.ch], 5'h00};
          above = $signed(v) > $signed(th);
          below = $signed(v) < $signed(16'(th - {3'h0, q.hyst, 5'h00}));
          if (above) begin
            n.ot_a[q.ch] = 1'b1;
          end else if (below) begin
            n.ot_a[q.ch] = 1'b0;
          end
          if ((q.ch == 3'd3) || (q.ch == 3'd4)) begin
            hi = above ? ((q.fq_hi[qi] == `MTC_FQ_DEPTH) ? `MTC_FQ_DEPTH :
                          2'(q.fq_hi[qi] + 2'd1)) : 2'd0;
            lo = below ? ((q.fq_lo[qi] == `MTC_FQ_DEPTH) ? `MTC_FQ_DEPTH :
                          2'(q.fq_lo[qi] + 2'd1)) : 2'd0;
            n.fq_hi[qi] = hi;
            n.fq_lo[qi] = lo;
            // R16: queue enable per remote
            if (q.cfg[qi]) begin
              n.ot_a[q.ch] = q.ot_a[q.ch];
              // R14: three highs in a row
              if (hi == `MTC_FQ_DEPTH) begin
                n.ot_a[q.ch] = 1'b1;
              end
              // R15: three lows in a row
              if (lo == `MTC_FQ_DEPTH) begin
                n.ot_a[q.ch] = 1'b0;
              end
            end
          end
          // Remotes one and two have their own second limit
          if ((q.ch == 3'd1) || (q.ch == 3'd2)) begin
            th = {3'h0, q.lim_b[fi], 5'h00};
            if ($signed(v) > $signed(th)) begin
              n.ot_b[q.ch] = 1'b1;
            end else if ($signed(v) < $signed(16'(th - {3'h0, q.hyst, 5'h00}))) begin
              n.ot_b[q.ch] = 1'b0;
            end
          end else begin
            n.ot_b[q.ch] = n.ot_a[q.ch];
          end
          // R4 R24: skip disabled channels at once
          nxt = next_en(q.chen, 3'(q.ch + 3'd1));
          n.slot = 32'h0;
          if (nxt == 3'd5) begin
            n.sq = SQ_WAIT;
            n.nrdy = 1'b0;
          end else begin
            n.ch = nxt;
            n.adc_go = 1'b1;
          end
        end
      end
    endcase

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    rdb = 8'h00;
    if (q.ptr == `MTC_REG_STATUS) begin
      // R2: busy only while converting
      rdb[`MTC_ST_BUSY] = (q.sq == SQ_CONV);
      rdb[`MTC_ST_NRDY] = q.nrdy;
      rdb[2:0] = {|q.ot_b, |q.ot_b, |q.ot_a};
    end else if (q.ptr == `MTC_REG_CONFIG) begin
      rdb = q.cfg;
    end else if (q.ptr == `MTC_REG_CHEN) begin
      rdb = {3'h0, q.chen};
    end else if (q.ptr == `MTC_REG_FILTER) begin
      rdb = {4'h0, q.filt};
    end else if (q.ptr[2:0] < 3'd5) begin
      // Temperature and per-channel registers
      if ((q.ptr & 8'hf8) == `MTC_REG_TS_MSB) begin
        rdb = res.rdata[15:8];
      end else if ((q.ptr & 8'hf8) == `MTC_REG_TS_LSB) begin
        rdb = res.rdata[7:0];
      end else if ((q.ptr & 8'hf8) == `MTC_REG_TU_MSB) begin
        rdb = res.rdata[31:24];
      end else if ((q.ptr & 8'hf8) == `MTC_REG_TU_LSB) begin
        rdb = res.rdata[23:16];
      end else if ((q.ptr & 8'hf8) == `MTC_REG_LIM_A) begin
        rdb = q.lim_a[q.ptr[2:0]];
      end else if (((q.ptr & 8'hf8) == `MTC_REG_OFFSET) && (q.ptr[2:0] != 3'd0)) begin
        rdb = q.off[2'(q.ptr[2:0] - 3'd1)];
      end else if (((q.ptr & 8'hf8) == `MTC_REG_LIM_B) && (q.ptr[2:1] == 2'b00) &&
                   (q.ptr[0] == 1'b1)) begin
        rdb = q.lim_b[0];
      end else if (q.ptr == (`MTC_REG_LIM_B + 8'h02)) begin
        rdb = q.lim_b[1];
      end
    end
    if (q.ptr == `MTC_REG_MODEL) rdb = {4'h0, q.model};
    if (q.ptr == `MTC_REG_HYST) rdb = q.hyst;
    if (q.ptr == `MTC_REG_MASK_A) rdb = {3'h0, q.mask_a};
    if (q.ptr == `MTC_REG_MASK_B) rdb = {3'h0, q.mask_b};
    if (q.ptr == `MTC_REG_MASK_C) rdb = {3'h0, q.mask_c};
    if (q.ptr == `MTC_REG_STAT_A) rdb = {3'h0, q.ot_a};
    if (q.ptr == `MTC_REG_STAT_B) rdb = {3'h0, q.ot_b};
    if (q.ptr == `MTC_REG_STAT_C) rdb = {3'h0, q.ot_b};
    // R20: fixed identity codes
    if (q.ptr == `MTC_REG_MFR) rdb = MFR_ID;
    if (q.ptr == `MTC_REG_REV) rdb = REV_ID;

    // ----------------------------------------
    // Serial slave port
    // ----------------------------------------
    // R23: count while either line is low
    if (!q.scl_s || !q.sda_s) begin
      if (q.tmo != 32'(TOUT_CYC)) n.tmo = q.tmo + 32'h1;
    end else begin
      n.tmo = 32'h0;
    end
    unique case (q.sm)
      SM_IDLE: begin
        n.dat_oe = 1'b0;
      end
      SM_RX: begin
        if (rise) begin
          n.sh = {q.sh[6:0], q.sda_s};
          n.bcnt = q.bcnt + 4'h1;
        end else if (fall && (q.bcnt == 4'h8)) begin
          n.sm = SM_ACK;
          n.dat_oe = 1'b1;
          if (q.bidx == 2'd0) begin
            // R11: ignore other addresses
            if (q.sh[7:1] == addr) begin
              n.rw = q.sh[0];
            end else begin
              n.sm = SM_IDLE;
              n.dat_oe = 1'b0;
            end
          end else if (q.bidx == 2'd1) begin
            n.ptr = q.sh;
          end else if (q.ptr == `MTC_REG_CONFIG) begin
            n.cfg = q.sh;
          end else if (q.ptr == `MTC_REG_CHEN) begin
            n.chen = q.sh[4:0];
          end else if (q.ptr == `MTC_REG_FILTER) begin
            n.filt = q.sh[3:0];
          end else if (q.ptr == `MTC_REG_MODEL) begin
            n.model = q.sh[3:0];
          end else if (q.ptr == `MTC_REG_HYST) begin
            n.hyst = q.sh;
          end else if (q.ptr == `MTC_REG_MASK_A) begin
            n.mask_a = q.sh[4:0];
          end else if (q.ptr == `MTC_REG_MASK_B) begin
            n.mask_b = q.sh[4:0];
          end else if (q.ptr == `MTC_REG_MASK_C) begin
            n.mask_c = q.sh[4:0];
          end else if (((q.ptr & 8'hf8) == `MTC_REG_LIM_A) && (q.ptr[2:0] < 3'd5)) begin
            n.lim_a[q.ptr[2:0]] = q.sh;
          end else if (q.ptr == (`MTC_REG_LIM_B + 8'h01)) begin
            n.lim_b[0] = q.sh;
          end else if (q.ptr == (`MTC_REG_LIM_B + 8'h02)) begin
            n.lim_b[1] = q.sh;
          end else if (((q.ptr & 8'hf8) == `MTC_REG_OFFSET) && (q.ptr[2:0] != 3'd0) &&
                       (q.ptr[2:0] < 3'd5)) begin
            n.off[2'(q.ptr[2:0] - 3'd1)] = q.sh;
          end
        end
      end
      SM_ACK, SM_TXACK: begin
        // A master nack ends the read
        if (rise && (q.sm == SM_TXACK) && q.sda_s) begin
          n.sm = SM_IDLE;
        end else if (fall) begin
          n.dat_oe = 1'b0;
          n.bcnt = 4'h0;
          n.sm = SM_RX;
          if (q.bidx != 2'd2) n.bidx = q.bidx + 2'd1;
          if (q.rw) begin
            // Drive the first data bit right after this edge
            n.sm = SM_TX;
            n.dat_oe = ~rdb[7];
            n.sh = {rdb[6:0], 1'b0};
            n.bcnt = 4'h1;
          end
        end
      end
      SM_TX: begin
        // R10: data changes only after the master's falling edge
        if (fall) begin
          if (q.bcnt == 4'h8) begin
            n.dat_oe = 1'b0;
            n.sm = SM_TXACK;
          end else begin
            n.dat_oe = ~q.sh[7];
            n.sh = {q.sh[6:0], 1'b0};
            n.bcnt = q.bcnt + 4'h1;
          end
        end
      end
      default: begin
        n.sm = SM_IDLE;
        n.dat_oe = 1'b0;
      end
    endcase
    if (start) begin
      n.sm = SM_RX;
      n.bcnt = 4'h0;
      n.bidx = 2'd0;
      n.rw = 1'b0;
      n.dat_oe = 1'b0;
    end else if (stop) begin
      n.sm = SM_IDLE;
      n.dat_oe = 1'b0;
    end
    // R23: release the data line on timeout
    if (q.tmo == 32'(TOUT_CYC - 1)) begin
      n.sm = SM_IDLE;
      n.dat_oe = 1'b0;
    end
    n.dat_out = 1'b0;

    // R14: only unmasked channels reach the pins
    n.ota_oe = |(n.ot_a & ~n.mask_a);
    n.otb_oe = |(n.ot_b & ~n.mask_b);
    n.otc_oe = |(n.ot_b & ~n.mask_c);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= CTL_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from state
  assign smb_dat_out = q.dat_out;
  assign smb_dat_oe = q.dat_oe;
  assign adc_start = q.adc_go;
  assign adc_chan = q.ch;
  assign diode_model = q.model;
  assign overtemp_out_a_oe = q.ota_oe;
  assign overtemp_out_b_oe = q.otb_oe;
  assign overtemp_out_c_oe = q.otc_oe;
endmodule : mtc_ctrl

// File: testbench/mtc_chk_sva.sv
`timescale 1ns/1ps
module mtc_chk #(
  parameter int CONV_CYC = 20,
  parameter int TOUT_CYC = 500
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       smb_clk,
  input wire logic       smb_dat_out,
  input wire logic       smb_dat_oe,
  input wire logic       adc_start,
  input wire logic [2:0] adc_chan,
  input wire logic [3:0] diode_model,
  input wire logic       overtemp_out_b_oe
);
  // ----
  // Counters
  // ----
  logic [31:0] gap_q;   // Cycles since slot start
  logic [31:0] hold_q;  // Cycles data held low
  // Preset so the first slot after reset passes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_q  <= 32'(CONV_CYC);
      hold_q <= '0;
    end else begin
      gap_q  <= adc_start ? '0 : gap_q + 1;
      hold_q <= smb_dat_oe ? hold_q + 1 : '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  dat_low_a:
    assert property (!smb_dat_out) else $error("data out high");
  model_rst_a:
    assert property ($rose(nrst) |-> diode_model == 4'h1) else $error("bad model");
  pulse_one_a:
    assert property (adc_start |=> !adc_start) else $error("start too long");
  slot_len_a:
    assert property (adc_start |-> gap_q >= CONV_CYC - 1) else $error("slot short");
  chan_hold_a:
    assert property (adc_start |=> $stable(adc_chan) [*8]) else $error("chan moved");
  chan_rng_a:
    assert property (adc_start |-> adc_chan <= 3'd4) else $error("bad chan");
  oe_rise_a:
    assert property ($rose(smb_dat_oe) |-> !smb_clk) else $error("rise in high");
  oe_fall_a:
    assert property ($fell(smb_dat_oe) |-> !smb_clk) else $error("fall in high");
  bus_tout_a:
    assert property (hold_q < TOUT_CYC + 8) else $error("held past timeout");
  cover property ($rose(smb_dat_oe));
  cover property ($rose(overtemp_out_b_oe));
  cover property (adc_start && adc_chan == 3'd4);
endmodule : mtc_chk
bind mtc_ctrl mtc_chk #(.CONV_CYC(CONV_CYC), .TOUT_CYC(TOUT_CYC)) i_mtc_chk (
  .clk(clk), .nrst(nrst), .smb_clk(smb_clk), .smb_dat_out(smb_dat_out),
  .smb_dat_oe(smb_dat_oe), .adc_start(adc_start), .adc_chan(adc_chan),
  .diode_model(diode_model), .overtemp_out_b_oe(overtemp_out_b_oe));

// File: testbench/mtc_host.sv
`timescale 1ns/1ps
module mtc_host (
  output logic      scl,
  output logic      dl,  // High pulls data low
  input  wire logic sda
);
  // ----
  // Bus master
  // ----
  initial begin
    scl = 1'b1;
    dl  = 1'b0;
  end
  task automatic bt(input logic b, output logic r);
    #23 dl = !b;
    #50 scl = 1'b1;
    r = sda;
    #80 scl = 1'b0;
    #7;
  endtask : bt
  // Start or stop: data edge while clock high
  task automatic st(input logic s);
    #23 dl = s;
    #50 scl = 1'b1;
    #80 dl = !s;
    #80 scl = s;
    #7;
  endtask : st
  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, k);
  endtask : xb
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    st(1'b0);
    xb({a, 1'b0}, q, k0);
    xb(p, q, k1);
    xb(d, q, k2);
    st(1'b1);
    ok = !(k0 | k1 | k2);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q);
    logic k;
    st(1'b0);
    xb({a, 1'b0}, q, k);
    xb(p, q, k);
    st(1'b0);
    xb({a, 1'b1}, q, k);
    xb(8'hff, q, k);
    st(1'b1);
  endtask : rd
endmodule : mtc_host

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mtc_pkg::*;
  localparam int CONV = 400;
  localparam logic [15:0] RV [11] = '{16'h0307, 16'h0f0f, 16'h051f, 16'h3801, 16'h3100,
    16'h4055, 16'h416e, 16'h5019, 16'hfe5a, 16'hff13, 16'h7f00};
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  mtc_asel_t  asel = 2'b00;
  mtc_adc_t   adc = '0;
  mtc_adc_t   x [5];  // Sample per channel
  logic [2:0] chan;
  logic [6:0] addr = 7'h18;
  logic [7:0] q;
  logic [15:0] r;
  logic       st, oe, oa, ob, oc, scl, dl, ok;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         n;
  wire        sda = !(dl | oe);  // Pull-up on open drain
  always #10 clk = ~clk;
  always @(posedge clk) adc <= x[chan];
  mtc_ctrl #(.CONV_CYC(CONV), .IVL_CYC(4000), .TOUT_CYC(500)) i_mtc_ctrl (
    .clk(clk), .nrst(nrst), .smb_clk(scl), .smb_dat(sda), .smb_dat_out(),
    .smb_dat_oe(oe), .address_select_pin(asel), .adc_data(adc), .adc_start(st),
    .adc_chan(chan), .diode_model(), .overtemp_out_a_oe(oa), .overtemp_out_b_oe(ob),
    .overtemp_out_c_oe(oc));
  mtc_host i_mtc_host (.scl(scl), .dl(dl), .sda(sda));
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rg(input logic [7:0] p, e);
    i_mtc_host.rd(addr, p, q);
    chk(16'(q), 16'(e));
  endtask : rg
  // Bounded wait for a slot start on channel c
  task automatic ws(input logic [2:0] c);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(st === 1'b1 && chan === c) && n < 20000);
    if (n >= 20000) begin
      n_fail++;
      final_report();
    end
  endtask : ws
  initial begin
    x = '{14'h3ffc, 14'd833, 14'd866, 14'd896, 14'd928};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rg(8'h14, 8'h00);
    rg(8'h02, 8'hc0);
    i_mtc_host.wr(addr, 8'hfe, 8'h00, ok);
    foreach (RV[i]) begin
      rg(RV[i][15:8], RV[i][7:0]);
    end
    ws(4);
    repeat (CONV + 20) @(negedge clk);
    rg(8'h02, 8'h00);
    for (int c = 0; c < 5; c++) begin
      i_mtc_host.rd(addr, 8'(8'h10 + c), r[15:8]);
      i_mtc_host.rd(addr, 8'(8'h20 + c), r[7:0]);
      chk(r, 16'(x[c]) << 3);
    end
    $display("reset and format done");
    for (int f = 0; f < 4; f++) begin
      i_mtc_host.wr(addr, 8'h0f, 8'(12 + f), ok);
      ws(1);
      ws(2);
      rg(8'h21, f[0] ? 8'h08 : 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) asel <= 2'(i);
      addr = (i == 0) ? 7'h18 : (i == 1) ? 7'h4d : 7'h4e;
      i_mtc_host.wr(addr, 8'h31, 8'h00, ok);
      chk(16'(ok), 16'h0001);
      i_mtc_host.wr(addr ^ 7'h01, 8'h31, 8'h00, ok);
      chk(16'(ok), 16'h0000);
    end
    i_mtc_host.wr(addr, 8'h05, 8'h1b, ok);
    ws(4);
    ws(1);
    ws(3);
    chk(16'(n), 16'(CONV));
    i_mtc_host.wr(addr, 8'h03, 8'h0b, ok);
    ws(0);
    ws(0);
    chk(16'(n >= 8000 && n <= 8001), 16'h0001);
    ws(1);
    chk(16'(n), 16'(CONV));
    i_mtc_host.wr(addr, 8'h03, 8'h07, ok);
    $display("sequencing done");
    ws(4);
    x[3] = 14'd2880;
    for (int k = 1; k < 7; k++) begin
      ws(4);
      repeat (10) @(negedge clk);
      chk({oa, ob, oc}, (k >= 3 && k <= 5) ? 16'h0003 : 16'h0000);
      if (k == 3) x[3] = 14'd896;
    end
    i_mtc_host.wr(addr, 8'h03, 8'h06, ok);
    ws(4);
    x[3] = 14'd2880;
    ws(4);
    repeat (10) @(negedge clk);
    chk(16'(ob), 16'h0001);
    i_mtc_host.st(1'b0);
    for (int i = 7; i >= 0; i--) i_mtc_host.bt(i > 0 ? addr[i - 1] : 1'b0, ok);
    repeat (10) @(negedge clk);
    chk(16'(oe), 16'h0001);
    repeat (520) @(negedge clk);
    chk(16'(oe), 16'h0000);
    i_mtc_host.st(1'b1);
    rg(8'hff, 8'h13);
    $display("limits and bus done");
    final_report();
  end
endmodule : tb_top
